// ==== pmc_pkg.sv ====
// Purpose: constants for the miscellaneous PCI configuration register bank
// Assumes: 32-bit configuration data, dword addressing by byte offset
// Notes: offsets, the write mask and command codes are shared with the testbench
package pmc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] MISC_CFG_OFFSET = 8'hf0;
  localparam logic [7:0] PM_CAP_OFFSET = 8'h44;
  localparam logic [31:0] MISC_CFG_RESET = 32'h0000_0000;
  // Writable bits 15, 10, 9-8, 4-0
  localparam logic [31:0] MISC_CFG_WMASK = 32'h0000_871f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PME_COLD_BIT = 15;
  localparam int PME_IGN_BIT = 10;
  localparam int RD_SEL_LO = 8;
  localparam int NO_ABORT_BIT = 4;
  localparam int GPIO_ROUTE_BIT = 3;
  localparam int LINK_BYP_BIT = 2;
  localparam int HOST_BYP_BIT = 1;
  localparam int KEEP_CLK_BIT = 0;
  // Position of cold PME support inside the capability register at 44h
  localparam int PM_CAP_COLD_BIT = 31;
  localparam int VID_IGN_BIT = 26;
  localparam int EE_SEL_LO = 0;
  localparam logic [7:0] ABORT_FILL = 8'hff;
  // ----------------------------------------
  // Master read commands
  // ----------------------------------------
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_READ_MULT = 4'hc;
  localparam logic [3:0] CMD_READ_LINE = 4'he;
  // Longest master read that always uses the plain read command
  localparam logic [7:0] SHORT_RD_MAX = 8'h02;
  localparam logic [1:0] SEL_LINE = 2'h0;
  localparam logic [1:0] SEL_READ = 2'h1;
  localparam logic [1:0] SEL_MULT = 2'h2;
endpackage

// ==== pmc_misc_cfg.sv ====
// Purpose: miscellaneous PCI configuration register and the logic it steers
// Assumes: configuration cycles arrive decoded as a one-cycle read or write strobe
// Notes: all outputs are registered, so effects appear one cycle after a change, five cycles for the general pin inputs
`timescale 1ns/1ns
module pmc_misc_cfg
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Configuration access
  input wire logic i_cfg_wr,
  input wire logic i_cfg_rd,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  // Serial EEPROM load
  input wire logic i_ee_load,
  input wire logic [15:0] i_ee_word12,
  // PME generation
  input wire logic i_irq_pending,
  input wire logic i_master_irq_gate,
  output logic o_pme_req,
  output logic o_pm_cap_cold,
  output logic o_vid_bit26,
  // Master read command
  input wire logic [7:0] i_rd_phases,
  output logic [3:0] o_rd_cmd,
  // Link register access
  input wire logic i_link_acc,
  input wire logic i_link_inactive,
  output logic o_target_abort,
  output logic o_link_done,
  output logic [7:0] o_link_fill,
  // General pins and EEPROM lines
  input wire logic i_gp_three_out,
  input wire logic i_gp_three_oe,
  input wire logic i_gp_two_out,
  input wire logic i_gp_two_oe,
  input wire logic i_gp_three_in,
  input wire logic i_gp_two_in,
  output logic o_general_pin_three_o,
  output logic o_general_pin_three_oe,
  output logic o_general_pin_two_o,
  output logic o_general_pin_two_oe,
  output logic o_ee_scl_in,
  output logic o_ee_sda_in,
  // Clock controls
  output logic o_link_clock_gate_bypass,
  output logic o_host_clock_gate_bypass,
  output logic o_keep_host_clock
);

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [31:0] misc_q;
  logic [31:0] misc_d;
  logic [31:0] wmask;
  logic hit;
  logic [2:0] three_s_q;
  logic [2:0] two_s_q;
  logic three_q, two_q;

  assign hit = (i_cfg_addr == pmc_pkg::MISC_CFG_OFFSET);

  always_comb
  begin
    wmask = pmc_pkg::MISC_CFG_WMASK & {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                                       {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    misc_d = misc_q;
    if (i_cfg_wr && hit)
    begin
      misc_d = (misc_q & ~wmask) | (i_cfg_wdata & wmask);
    end
    if (i_ee_load)
    begin
      misc_d[pmc_pkg::RD_SEL_LO +: 2] = i_ee_word12[pmc_pkg::EE_SEL_LO +: 2];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      misc_q <= pmc_pkg::MISC_CFG_RESET;
    else
      misc_q <= misc_d;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_cfg_rdata <= '0;
      o_cfg_rvalid <= 1'b0;
    end
    else
    begin
      o_cfg_rvalid <= i_cfg_rd;
      o_cfg_rdata <= (i_cfg_rd && hit) ? (misc_q & pmc_pkg::MISC_CFG_WMASK) : '0;
    end
  end

  // ----------------------------------------
  // PME and mirrored bits
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_pme_req <= 1'b0;
      o_pm_cap_cold <= 1'b0;
      o_vid_bit26 <= 1'b0;
    end
    else
    begin
      o_pme_req <= i_irq_pending &&
                   (i_master_irq_gate || misc_q[pmc_pkg::PME_IGN_BIT]);
      o_pm_cap_cold <= misc_q[pmc_pkg::PME_COLD_BIT];
      o_vid_bit26 <= misc_q[pmc_pkg::PME_IGN_BIT];
    end
  end

  // ----------------------------------------
  // Master read command
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_rd_cmd <= pmc_pkg::CMD_MEM_READ;
    else if (i_rd_phases <= pmc_pkg::SHORT_RD_MAX)
      o_rd_cmd <= pmc_pkg::CMD_MEM_READ;
    else
    begin
      case (misc_q[pmc_pkg::RD_SEL_LO +: 2])
        pmc_pkg::SEL_READ: o_rd_cmd <= pmc_pkg::CMD_MEM_READ;
        pmc_pkg::SEL_MULT: o_rd_cmd <= pmc_pkg::CMD_READ_MULT;
        default: o_rd_cmd <= pmc_pkg::CMD_READ_LINE;
      endcase
    end
  end

  // ----------------------------------------
  // Inactive link access reply
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_target_abort <= 1'b0;
      o_link_done <= 1'b0;
      o_link_fill <= '0;
    end
    else
    begin
      o_target_abort <= i_link_acc && i_link_inactive && !misc_q[pmc_pkg::NO_ABORT_BIT];
      o_link_done <= i_link_acc && i_link_inactive && misc_q[pmc_pkg::NO_ABORT_BIT];
      o_link_fill <= (i_link_acc && i_link_inactive && misc_q[pmc_pkg::NO_ABORT_BIT])
                     ? pmc_pkg::ABORT_FILL : '0;
    end
  end

  // ----------------------------------------
  // General pins
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      three_s_q <= '1;
      two_s_q <= '1;
      three_q <= 1'b1;
      two_q <= 1'b1;
    end
    else
    begin
      three_s_q <= {three_s_q[1:0], i_gp_three_in};
      two_s_q <= {two_s_q[1:0], i_gp_two_in};
      if (three_s_q[2] == three_s_q[1])
        three_q <= three_s_q[2];
      if (two_s_q[2] == two_s_q[1])
        two_q <= two_s_q[2];
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_general_pin_three_o <= 1'b0;
      o_general_pin_three_oe <= 1'b0;
      o_general_pin_two_o <= 1'b0;
      o_general_pin_two_oe <= 1'b0;
      o_ee_scl_in <= 1'b1;
      o_ee_sda_in <= 1'b1;
    end
    else
    begin
      o_general_pin_three_o <= i_gp_three_out;
      o_general_pin_two_o <= i_gp_two_out;
      o_general_pin_three_oe <= i_gp_three_oe && !misc_q[pmc_pkg::GPIO_ROUTE_BIT];
      o_general_pin_two_oe <= i_gp_two_oe && !misc_q[pmc_pkg::GPIO_ROUTE_BIT];
      o_ee_scl_in <= misc_q[pmc_pkg::GPIO_ROUTE_BIT] ? three_q : 1'b1;
      o_ee_sda_in <= misc_q[pmc_pkg::GPIO_ROUTE_BIT] ? two_q : 1'b1;
    end
  end

  // ----------------------------------------
  // Clock controls
  // ----------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_link_clock_gate_bypass <= 1'b0;
      o_host_clock_gate_bypass <= 1'b0;
      o_keep_host_clock <= 1'b0;
    end
    else
    begin
      o_link_clock_gate_bypass <= misc_q[pmc_pkg::LINK_BYP_BIT];
      o_host_clock_gate_bypass <= misc_q[pmc_pkg::HOST_BYP_BIT];
      o_keep_host_clock <= misc_q[pmc_pkg::KEEP_CLK_BIT];
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  reserved_zero_a: assert property (o_cfg_rdata[31:16] == '0 && o_cfg_rdata[14:11] == '0
    && o_cfg_rdata[7:5] == '0) else $error("reserved bits read nonzero");
  cap_mirror_a: assert property (##1 o_pm_cap_cold == $past(misc_q[pmc_pkg::PME_COLD_BIT]))
    else $error("capability mirror wrong");
  pme_gate_a: assert property (i_irq_pending && !i_master_irq_gate
    && !misc_q[pmc_pkg::PME_IGN_BIT] |=> !o_pme_req) else $error("pme not gated");
  vid_bit_a: assert property (misc_q[pmc_pkg::PME_IGN_BIT] |=> o_vid_bit26)
    else $error("vendor bit 26 not set");
  short_read_a: assert property (i_rd_phases <= pmc_pkg::SHORT_RD_MAX
    |=> o_rd_cmd == pmc_pkg::CMD_MEM_READ) else $error("short read command wrong");
  long_read_a: assert property (i_rd_phases > pmc_pkg::SHORT_RD_MAX
    && misc_q[pmc_pkg::RD_SEL_LO +: 2] == 2'h3 |=> o_rd_cmd == pmc_pkg::CMD_READ_LINE)
    else $error("reserved select wrong");
  ee_load_a: assert property (i_ee_load |=> misc_q[pmc_pkg::RD_SEL_LO +: 2]
    == $past(i_ee_word12[pmc_pkg::EE_SEL_LO +: 2])) else $error("eeprom load missed");
  abort_reply_a: assert property (i_link_acc && i_link_inactive && !misc_q[pmc_pkg::NO_ABORT_BIT]
    |=> o_target_abort && !o_link_done) else $error("abort missing");
  fill_reply_a: assert property (i_link_acc && i_link_inactive && misc_q[pmc_pkg::NO_ABORT_BIT]
    |=> !o_target_abort && o_link_fill == pmc_pkg::ABORT_FILL) else $error("bad fill");
  pin_hiz_a: assert property (misc_q[pmc_pkg::GPIO_ROUTE_BIT]
    |=> !o_general_pin_three_oe && !o_general_pin_two_oe) else $error("pins driven");
  ro_bits_a: assert property (i_cfg_wr && !i_ee_load
    |=> (misc_q & ~pmc_pkg::MISC_CFG_WMASK) == '0) else $error("read-only bit stored");
  keep_clk_a: assert property (##1 o_keep_host_clock == $past(misc_q[pmc_pkg::KEEP_CLK_BIT]))
    else $error("keep clock wrong");

  write_c: cover property (i_cfg_wr && hit);
  fill_c: cover property (o_link_done);
  route_c: cover property (o_ee_scl_in == 1'b0);
  long_c: cover property (o_rd_cmd == pmc_pkg::CMD_READ_MULT);
endmodule

// ==== pmc_host_model.sv ====
// Purpose: host bridge model issuing configuration cycles
// Assumes: strobes are one-cycle pulses taken on the rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ns
module pmc_host_model
(
  // Clock
  input wire logic i_mclk,
  // Configuration cycle
  output logic o_cfg_wr,
  output logic o_cfg_rd,
  output logic [7:0] o_cfg_addr,
  output logic [3:0] o_cfg_be,
  output logic [31:0] o_cfg_wdata,
  input wire logic [31:0] i_cfg_rdata,
  input wire logic i_cfg_rvalid
);
  initial
  begin
    o_cfg_wr = 1'b0;
    o_cfg_rd = 1'b0;
    o_cfg_addr = 8'h00;
    o_cfg_be = 4'h0;
    o_cfg_wdata = 32'h0000_0000;
  end
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge i_mclk);
    o_cfg_wr <= 1'b1;
    o_cfg_addr <= a;
    o_cfg_be <= b;
    o_cfg_wdata <= d;
    @(posedge i_mclk);
    o_cfg_wr <= 1'b0;
    o_cfg_addr <= ~a;
    o_cfg_wdata <= ~d;
  endtask
  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    o_cfg_rd <= 1'b1;
    o_cfg_addr <= a;
    @(posedge i_mclk);
    o_cfg_rd <= 1'b0;
    o_cfg_addr <= ~a;
    // Answer stands for one cycle; take it at the edge that closes it
    @(posedge i_mclk);
    d = i_cfg_rvalid ? i_cfg_rdata : 32'hxxxx_xxxx;
  endtask
endmodule

// ==== pmc_misc_cfg_test.sv ====
// Purpose: self-checking bench for the miscellaneous configuration bank
// Assumes: host model drives configuration cycles, bench drives the rest
// Notes: random values come from an LFSR seeded with 21
`timescale 1ns/1ns
module pmc_misc_cfg_test;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cw, cr, ld, pend, gate, acc, inact, t_o, t_oe, w_o, w_oe, t_in, w_in;
  logic rv, pme, cold, v26, ab, dn, p3o, p3e, p2o, p2e, scl, sda, lb, hb, kc;
  logic [7:0] addr, ph, fill, ca;
  logic [3:0] be, cbe, cmd;
  logic [15:0] ew;
  logic [31:0] wd, cwd, rd, r, lf, got, m;
  int failures = 0;
  int compares = 0;
  always #4 i_mclk = ~i_mclk;
  pmc_host_model i_host (.i_mclk(i_mclk), .o_cfg_wr(cw), .o_cfg_rd(cr), .o_cfg_addr(ca),
    .o_cfg_be(cbe), .o_cfg_wdata(cwd), .i_cfg_rdata(rd), .i_cfg_rvalid(rv));
  pmc_misc_cfg i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_wr(cw), .i_cfg_rd(cr),
    .i_cfg_addr(ca), .i_cfg_be(cbe), .i_cfg_wdata(cwd), .o_cfg_rdata(rd), .o_cfg_rvalid(rv),
    .i_ee_load(ld), .i_ee_word12(ew), .i_irq_pending(pend), .i_master_irq_gate(gate),
    .o_pme_req(pme), .o_pm_cap_cold(cold), .o_vid_bit26(v26), .i_rd_phases(ph),
    .o_rd_cmd(cmd), .i_link_acc(acc), .i_link_inactive(inact), .o_target_abort(ab),
    .o_link_done(dn), .o_link_fill(fill), .i_gp_three_out(t_o), .i_gp_three_oe(t_oe),
    .i_gp_two_out(w_o), .i_gp_two_oe(w_oe), .i_gp_three_in(t_in), .i_gp_two_in(w_in),
    .o_general_pin_three_o(p3o), .o_general_pin_three_oe(p3e), .o_general_pin_two_o(p2o),
    .o_general_pin_two_oe(p2e), .o_ee_scl_in(scl), .o_ee_sda_in(sda),
    .o_link_clock_gate_bypass(lb), .o_host_clock_gate_bypass(hb), .o_keep_host_clock(kc));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] exp_cmd(input logic [1:0] s, input logic [7:0] p);
    if (p <= pmc_pkg::SHORT_RD_MAX || s == pmc_pkg::SEL_READ)
      return pmc_pkg::CMD_MEM_READ;
    return (s == pmc_pkg::SEL_MULT) ? pmc_pkg::CMD_READ_MULT : pmc_pkg::CMD_READ_LINE;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic outs();
    chk(32'(pme), 32'(pend & (gate | r[10])));
    chk(32'(cold), 32'(r[15]));
    chk(32'(v26), 32'(r[10]));
    chk(32'(cmd), 32'(exp_cmd(r[9:8], ph)));
    chk(32'(ab), 32'(acc & inact & ~r[4]));
    chk(32'({dn, fill}), 32'({9{acc & inact & r[4]}}));
    chk(32'({p3e, p2e}), 32'(r[3] ? 2'b00 : {t_oe, w_oe}));
    chk(32'({p3o, p2o}), 32'({t_o, w_o}));
    chk(32'({scl, sda}), 32'(r[3] ? {t_in, w_in} : 2'b11));
    chk(32'({lb, hb, kc}), 32'(r[2:0]));
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge i_mclk);
    failures++;
    give_verdict();
  end
  initial
  begin
    {ld, pend, gate, acc, inact, t_o, t_oe, w_o, w_oe, t_in, w_in} = '0;
    ph = 8'h00;
    ew = 16'h0000;
    r = 32'h0000_0000;
    lf = 32'h0000_0015;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1;
    outs();
    i_host.cfg_read(pmc_pkg::MISC_CFG_OFFSET, got);
    chk(got, 32'h0000_0000);
    for (int k = 0; k < 60; k++)
    begin
      lf = nxt(lf);
      wd = (k == 0) ? 32'hffff_ffff : lf;
      lf = nxt(lf);
      addr = (lf[0] || k == 0) ? pmc_pkg::MISC_CFG_OFFSET : {lf[8:3], 2'b00};
      be = (k == 0) ? 4'hf : lf[12:9];
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & pmc_pkg::MISC_CFG_WMASK;
      i_host.cfg_write(addr, be, wd);
      if (addr == pmc_pkg::MISC_CFG_OFFSET)
        r = (r & ~m) | (wd & m);
      if (lf[20])
      begin
        ew <= lf[31:16];
        ld <= 1'b1;
        @(posedge i_mclk);
        ld <= 1'b0;
        r[9:8] = lf[17:16];
      end
      lf = nxt(lf);
      {pend, gate, acc, inact, t_oe, w_oe, t_in, w_in, t_o, w_o} <= lf[9:0];
      ph <= {5'h00, lf[12:10]};
      repeat (6) @(posedge i_mclk);
      #1;
      outs();
      i_host.cfg_read(pmc_pkg::MISC_CFG_OFFSET, got);
      chk(got, r);
    end
    i_host.cfg_read(pmc_pkg::PM_CAP_OFFSET, got);
    chk(got, 32'h0000_0000);
    i_host.cfg_write(pmc_pkg::MISC_CFG_OFFSET, 4'hf, 32'h0000_0010);
    r = 32'h0000_0010;
    {acc, inact} <= 2'b11;
    repeat (3) @(posedge i_mclk);
    #1;
    outs();
    give_verdict();
  end
endmodule
